/* verilog/mbhp_port.sv */
`timescale 1ns/1ns
module mbhp_port
    import mbhp_pkg::*;
#(
    parameter int unsigned LOCATIONS = MBHP_LOCATIONS
)
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // Static configuration and supply status
    input wire logic I_PROTOCOL_SELECT,
    input wire logic I_POWER_FAIL,
    input wire logic I_DEV_RESET_B,
    // Bus strobes
    input wire logic I_ADDRESS_STROBE,
    input wire logic I_DATA_STROBE,
    input wire logic I_RW,
    input wire logic I_CS_B,
    // Shared address/data lines, split
    input wire logic [7:0] I_SHARED_ADDR_DATA_LINES,
    output logic [7:0] O_SHARED_ADDR_DATA_LINES,
    output logic O_SHARED_ADDR_DATA_OE,
    // Core view of access events
    output logic O_WRITE_PULSE,
    output logic [6:0] O_ACCESS_ADDR,
    output logic O_ADDR_VALID
);

    // =====================================================================
    // Input synchronisation
    logic [3:0] sync_s;
    logic as_s;
    logic dstrobe_s;
    logic rw_s;
    logic cs_b_s;
    logic as_d1_q;
    logic dstrobe_d1_q;
    logic rw_d1_q;
    logic [7:0] bus_s1_q;
    logic [7:0] bus_s2_q;
    logic [7:0] bus_d1_q;

    // I_RW and I_CS_B idle high and pass inverted so the synchroniser's reset value matches
    // their idle level; I_DATA_STROBE passes as is, so dstrobe_s rises after reset when I_PROTOCOL_SELECT is low
    mbhp_sync #(.WIDTH(4)) u_sync (
        .I_CLK(I_CLK),
        .I_RST_B(I_RST_B),
        .i_async({I_ADDRESS_STROBE, I_DATA_STROBE, ~I_RW, ~I_CS_B}),
        .o_sync(sync_s)
    );

    assign as_s = sync_s[3];
    assign dstrobe_s = sync_s[2];
    assign rw_s = ~sync_s[1];
    assign cs_b_s = ~sync_s[0];

    // Lines pass through the same depth plus one, so the sample at an edge
    // reflects the value that stood before the strobe moved.
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            as_d1_q <= 1'b0;
            dstrobe_d1_q <= 1'b0;
            rw_d1_q <= 1'b1;
            bus_s1_q <= 8'h00;
            bus_s2_q <= 8'h00;
            bus_d1_q <= 8'h00;
        end
        else
        begin
            as_d1_q <= as_s;
            dstrobe_d1_q <= dstrobe_s;
            rw_d1_q <= rw_s;
            bus_s1_q <= I_SHARED_ADDR_DATA_LINES;
            bus_s2_q <= bus_s1_q;
            bus_d1_q <= bus_s2_q;
        end
    end

    // =====================================================================
    // Edges and qualifiers
    logic as_fall;
    logic as_rise;
    logic dstrobe_fall;
    logic dstrobe_rise;
    logic rw_rise;
    logic mode_dstrobe;
    logic selected;
    logic write_ev;
    logic access_end;
    logic read_win;

    assign as_fall = as_d1_q & ~as_s;
    assign as_rise = ~as_d1_q & as_s;
    assign dstrobe_fall = dstrobe_d1_q & ~dstrobe_s;
    assign dstrobe_rise = ~dstrobe_d1_q & dstrobe_s;
    assign rw_rise = ~rw_d1_q & rw_s;
    assign mode_dstrobe = I_PROTOCOL_SELECT;
    // Power fail and held reset both look like a deselected chip
    assign selected = ~cs_b_s & ~I_POWER_FAIL & I_DEV_RESET_B;

    // =====================================================================
    // Address latch and cycle state
    mbhp_state_t state_q;
    logic [6:0] addr_q;

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            state_q <= MBHP_IDLE;
            addr_q <= MBHP_ADDR_RESET;
        end
        else
        begin
            if (as_rise)
            begin
                state_q <= MBHP_IDLE;
            end
            else if (as_fall)
            begin
                state_q <= MBHP_ADDR_HELD;
                addr_q <= bus_d1_q[6:0];
            end
            else if (state_q == MBHP_ADDR_HELD && access_end)
            begin
                // One access per captured address; deselected cycles also consume it
                state_q <= MBHP_DONE;
            end
        end
    end

    // =====================================================================
    // Access decode
    always_comb
    begin
        if (mode_dstrobe)
        begin
            write_ev = dstrobe_fall & ~rw_d1_q;
            access_end = dstrobe_fall;
            read_win = dstrobe_s & rw_s;
        end
        else
        begin
            write_ev = rw_rise;
            access_end = rw_rise | dstrobe_rise;
            read_win = ~dstrobe_s & rw_s;
        end
    end

    // =====================================================================
    // Storage
    logic [7:0] mem_q [LOCATIONS];
    logic do_write;

    assign do_write = write_ev & selected & (state_q == MBHP_ADDR_HELD);

    genvar gi;
    generate
        for (gi = 0; gi < LOCATIONS; gi++)
        begin : g_loc
            always_ff @(posedge I_CLK or negedge I_RST_B)
            begin
                if (!I_RST_B)
                begin
                    mem_q[gi] <= MBHP_MEM_RESET;
                end
                else if (do_write && addr_q == 7'(gi))
                begin
                    mem_q[gi] <= bus_d1_q;
                end
            end
        end
    endgenerate

    // =====================================================================
    // Read drive; data registered, enable follows the read window
    logic [7:0] rdata_q;
    logic oe_q;

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            rdata_q <= 8'h00;
            oe_q <= 1'b0;
        end
        else
        begin
            rdata_q <= mem_q[addr_q];
            oe_q <= read_win & selected & (state_q == MBHP_ADDR_HELD) & ~access_end;
        end
    end

    assign O_SHARED_ADDR_DATA_LINES = rdata_q;
    assign O_SHARED_ADDR_DATA_OE = oe_q;

    // =====================================================================
    // Core notification
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_WRITE_PULSE <= 1'b0;
            O_ACCESS_ADDR <= MBHP_ADDR_RESET;
            O_ADDR_VALID <= 1'b0;
        end
        else
        begin
            O_WRITE_PULSE <= do_write;
            O_ACCESS_ADDR <= addr_q;
            O_ADDR_VALID <= (state_q == MBHP_ADDR_HELD);
        end
    end

endmodule // mbhp_port

/* verilog/mbhp_pkg.sv */
package mbhp_pkg;

    // =====================================================================
    // Geometry
    localparam int unsigned MBHP_ADDR_W = 7;
    localparam int unsigned MBHP_DATA_W = 8;
    localparam int unsigned MBHP_LOCATIONS = 128;
    localparam int unsigned MBHP_CLOCK_REGS = 14;
    localparam int unsigned MBHP_GP_BYTES = 114;

    // =====================================================================
    // Reset values
    localparam logic [7:0] MBHP_MEM_RESET = 8'h00;
    localparam logic [6:0] MBHP_ADDR_RESET = 7'h00;

    // =====================================================================
    // Synchroniser depth
    localparam int unsigned MBHP_SYNC_STAGES = 2;

    // =====================================================================
    // Cycle states
    typedef enum logic [1:0] {
        MBHP_IDLE,
        MBHP_ADDR_HELD,
        MBHP_DONE
    } mbhp_state_t;

endpackage

/* verilog/mbhp_sync.sv */
`timescale 1ns/1ns
module mbhp_sync
    import mbhp_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // Asynchronous levels in, synchronous levels out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // =====================================================================
    // Two-stage synchroniser; first stage feeds only the second
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule // mbhp_sync

/* test/mbhp_port_sva.sv */
`timescale 1ns/1ns
// ==========
// Bus port checker
module mbhp_port_sva
(
    // Clock and controls
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_PROTOCOL_SELECT,
    input wire logic I_POWER_FAIL,
    input wire logic I_DEV_RESET_B,
    // Strobes
    input wire logic I_ADDRESS_STROBE,
    input wire logic I_DATA_STROBE,
    input wire logic I_RW,
    input wire logic I_CS_B,
    // Watched outputs
    input wire logic O_SHARED_ADDR_DATA_OE,
    input wire logic O_WRITE_PULSE,
    input wire logic O_ADDR_VALID
);
    wire oe = O_SHARED_ADDR_DATA_OE;
    wire ps = I_PROTOCOL_SELECT;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    // Six cycles covers the synchroniser lag
    a_cs_blocks: assert property (I_CS_B [*6] |-> !O_WRITE_PULSE) else $error("deselected write");
    a_pf_blocks: assert property (I_POWER_FAIL [*6] |-> !O_WRITE_PULSE) else $error("power fail write");
    a_rst_blocks: assert property ((!I_DEV_RESET_B) [*6] |-> !O_WRITE_PULSE) else $error("reset write");
    a_read_dir: assert property ($rose(oe) |-> I_RW && $past(I_RW, 3)) else $error("drive on write");
    a_read_window: assert property ($rose(oe) |-> $past(I_DATA_STROBE, 3) == ps) else $error("early drive");
    a_bus_release: assert property ($changed(I_DATA_STROBE) && I_DATA_STROBE != ps |-> ##[1:5] !oe)
        else $error("late release");
    a_addr_take: assert property ($fell(I_ADDRESS_STROBE) |-> ##[2:5] O_ADDR_VALID) else $error("no address");
    a_addr_drop: assert property ($rose(I_ADDRESS_STROBE) |-> ##[2:5] !O_ADDR_VALID) else $error("stale address");
    c_read: cover property ($rose(oe));
    c_write: cover property (O_WRITE_PULSE);
    c_consume: cover property ($fell(O_ADDR_VALID));
endmodule // mbhp_port_sva

bind mbhp_port mbhp_port_sva chk_u (.I_CLK, .I_RST_B, .I_PROTOCOL_SELECT, .I_POWER_FAIL, .I_DEV_RESET_B,
    .I_ADDRESS_STROBE, .I_DATA_STROBE, .I_RW, .I_CS_B, .O_SHARED_ADDR_DATA_OE, .O_WRITE_PULSE, .O_ADDR_VALID);

/* test/mbhp_host_model.sv */
`timescale 1ns/1ns
// ==========
// Host processor on the multiplexed bus
module mbhp_host_model
(
    // Clock and bus mode
    input wire logic i_clk,
    input wire logic i_ps,
    // Device drive of the shared lines
    input wire logic [7:0] i_dq,
    input wire logic i_oe,
    // Host pins
    output logic o_as,
    output logic o_dstrobe,
    output logic o_rw,
    output logic o_cs_b,
    output logic [7:0] o_bus
);
    logic act = 1'b0, en = 1'b0, as_q = 1'b0, rw_q = 1'b1, cs_q = 1'b1;
    logic [7:0] drv = 8'h00, last_q = 8'h00;
    assign o_as = as_q;
    assign o_rw = rw_q;
    assign o_cs_b = cs_q;
    assign o_dstrobe = act ^ !i_ps;
    // Released lines toggle so a stale byte never passes for read data
    assign o_bus = i_oe ? i_dq : en ? drv : ~last_q;
    always @(posedge i_clk) last_q <= o_bus;
    task automatic tk(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Address phase only, no data phase; the next strobe must drop the held address
    task automatic addr_only(input logic [6:0] a);
        tk(1);
        drv <= {1'b0, a};
        en <= 1'b1;
        as_q <= 1'b1;
        tk(4);
        as_q <= 1'b0;
        tk(6);
        en <= 1'b0;
    endtask
    task automatic access(input logic sel, input logic [6:0] a, input logic wr, input logic [7:0] d,
        output logic [7:0] q);
        tk(1);
        cs_q <= sel;
        drv <= {1'b0, a};
        en <= 1'b1;
        as_q <= 1'b1;
        tk(4);
        as_q <= 1'b0;
        tk(4);
        drv <= d;
        en <= wr;
        rw_q <= !wr;
        tk(4);
        if (i_ps || !wr)
            act <= 1'b1;
        else
            rw_q <= 1'b1;
        tk(6);
        q = o_bus;
        act <= 1'b0;
        tk(6);
        rw_q <= 1'b1;
        cs_q <= 1'b1;
        en <= 1'b0;
    endtask
endmodule // mbhp_host_model

/* test/mbhp_port_tb.sv */
`timescale 1ns/1ns
// ==========
// Port bench
module mbhp_port_tb;
    logic clk = 1'b0, rst_b = 1'b0, ps = 1'b1, pf = 1'b0, dres_b = 1'b1;
    logic as_w, dstrobe_w, rw_w, cs_w, oe, wp, av;
    logic [6:0] aa;
    logic [7:0] bus, dq;
    int failures = 0, cmp_count = 0, wp_n = 0;
    mbhp_port dut_u (.I_CLK(clk), .I_RST_B(rst_b), .I_PROTOCOL_SELECT(ps), .I_POWER_FAIL(pf),
        .I_DEV_RESET_B(dres_b), .I_ADDRESS_STROBE(as_w), .I_DATA_STROBE(dstrobe_w), .I_RW(rw_w), .I_CS_B(cs_w),
        .I_SHARED_ADDR_DATA_LINES(bus), .O_SHARED_ADDR_DATA_LINES(dq), .O_SHARED_ADDR_DATA_OE(oe),
        .O_WRITE_PULSE(wp), .O_ACCESS_ADDR(aa), .O_ADDR_VALID(av));
    mbhp_host_model host_u (.i_clk(clk), .i_ps(ps), .i_dq(dq), .i_oe(oe), .o_as(as_w), .o_dstrobe(dstrobe_w),
        .o_rw(rw_w), .o_cs_b(cs_w), .o_bus(bus));
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (wp === 1'b1) wp_n++;
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_rw(input logic [7:0] d);
        logic [7:0] q;
        int n;
        n = wp_n;
        host_u.access(1'b0, 7'h05, 1'b1, d, q);
        host_u.access(1'b0, 7'h7f, 1'b1, ~d, q);
        chk("write pulses", 8'(wp_n - n), 8'h02);
        host_u.addr_only(7'h7f);
        chk("addr held", {7'h00, av}, 8'h01);
        chk("held addr", {1'b0, aa}, 8'h7f);
        host_u.access(1'b0, 7'h05, 1'b0, 8'h00, q);
        chk("read 05", q, d);
        chk("addr valid", {7'h00, av}, 8'h00);
        host_u.access(1'b0, 7'h7f, 1'b0, 8'h00, q);
        chk("read 7f", q, ~d);
        host_u.access(1'b0, 7'h06, 1'b0, 8'h00, q);
        chk("read 06", q, 8'h00);
    endtask
    task automatic t_block(input logic [7:0] d);
        logic [7:0] q;
        int n;
        n = wp_n;
        host_u.access(1'b1, 7'h05, 1'b1, 8'hff, q);
        chk("latched addr", {1'b0, aa}, 8'h05);
        pf <= 1'b1;
        host_u.access(1'b0, 7'h05, 1'b1, 8'hff, q);
        pf <= 1'b0;
        dres_b <= 1'b0;
        host_u.access(1'b0, 7'h05, 1'b1, 8'hff, q);
        dres_b <= 1'b1;
        chk("blocked writes", 8'(wp_n - n), 8'h00);
        host_u.access(1'b0, 7'h05, 1'b0, 8'h00, q);
        chk("kept byte", q, d);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_rw(8'h5a);
        t_block(8'h5a);
        ps <= 1'b0;
        repeat (4) @(posedge clk);
        t_rw(8'hc3);
        t_block(8'hc3);
        results;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        results;
    end
endmodule // mbhp_port_tb
